// ==== core/urxs_top.sv ====
// serial receiver/transmitter with status word, overrun, parity and interrupt logic
// Operation
// - overrun arises at final bit of second character
// - overrun shown only after held character read
// - receive-full stays set until overrun cleared
// - receiver keeps character framing during overrun
// - overrun cleared by data read or master reset
// - parity mismatch flag from ones count
// - parity flag lives with held character
// - no-parity formats suppress generation and check
// - top status bit is inverted request line
// - enabled sources drive request and status bit
// - data read or data write releases request
// - status word read with select low, read high
// - receive interrupts gated by receive enable bit
// - transmit interrupt only for control code 01
// - master reset clears flags except transmit-empty and modem inputs
`include "urxs_defines.svh"

module urxs_top
    import urxs_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // processor bus
    input  wire logic       e_i,
    input  wire logic       cs0_i,
    input  wire logic       cs1_i,
    input  wire logic       cs2_n_i,
    input  wire logic       register_select_line_i,
    input  wire logic       rw_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    output logic            irq_n_o,
    // serial side
    input  wire logic       rxtx_clk_i,
    input  wire logic       rxd_i,
    output logic            txd_o,
    // modem control
    input  wire logic       cts_n_i,
    input  wire logic       dcd_n_i,
    output logic            rts_n_o
);
    urxs_state_t s_q;
    urxs_state_t s_d;
    urxs_fmt_t   fmt;
    logic [6:0]  ratio;
    logic [6:0]  half;
    logic [3:0]  nbits;
    logic [1:0]  tc;
    logic        mreset;
    logic        sel;
    logic        e_fall;
    logic        rd_data;
    logic        wr_data;
    logic        wr_ctrl;
    logic        rx_tick;
    logic        tx_tick;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [7:0]  fifo_out_data;
    logic        transmit_empty_flag;
    logic [7:0]  status;
    logic [7:0]  rx_char;
    logic        rx_src;
    logic        tx_src;
    function automatic urxs_fmt_t ws_decode(input logic [2:0] ws);
        urxs_fmt_t f;
        f.eight    = ws[2];
        f.par_en   = !(ws[2] && !ws[1]);
        f.par_odd  = ws[0];
        f.two_stop = !ws[1] && !(ws[2] && ws[0]);
        return f;
    endfunction
    function automatic logic [6:0] div_ratio(input logic [1:0] d, input logic want_half);
        logic [6:0] r;
        case (d)
            `URXS_DIV_16: r = want_half ? `URXS_HALF_16 : `URXS_RATIO_16;
            `URXS_DIV_64: r = want_half ? `URXS_HALF_64 : `URXS_RATIO_64;
            default:      r = want_half ? `URXS_HALF_1 : `URXS_RATIO_1;
        endcase
        return r;
    endfunction
    assign fmt     = ws_decode(s_q.ctrl[`URXS_CR_WS_HI:`URXS_CR_WS_LO]);
    assign ratio   = div_ratio(s_q.ctrl[`URXS_CR_DIV_HI:`URXS_CR_DIV_LO], 1'b0);
    assign half    = div_ratio(s_q.ctrl[`URXS_CR_DIV_HI:`URXS_CR_DIV_LO], 1'b1);
    assign nbits   = fmt.eight ? `URXS_BITS_8 : `URXS_BITS_7;
    assign tc      = s_q.ctrl[`URXS_CR_TC_HI:`URXS_CR_TC_LO];
    assign mreset  = (s_q.ctrl[`URXS_CR_DIV_HI:`URXS_CR_DIV_LO] == `URXS_DIV_MRESET);
    assign sel     = cs0_i && cs1_i && !cs2_n_i;
    // accesses act on the falling edge of the enable strobe
    assign e_fall  = s_q.e_prev && !e_i;
    assign rd_data = sel && e_fall && register_select_line_i && rw_i;
    assign wr_data = sel && e_fall && register_select_line_i && !rw_i;
    assign wr_ctrl = sel && e_fall && !register_select_line_i && !rw_i;
    assign rx_tick = rxtx_clk_i && !s_q.clk_prev;
    assign tx_tick = !rxtx_clk_i && s_q.clk_prev;
    // clear-to-send high hides the empty indication
    assign transmit_empty_flag = fifo_in_ready && !cts_n_i;
    assign fifo_out_ready      = (s_q.tx_st == tx_idle) && !mreset;
    assign rx_char = fmt.eight ? s_q.rx_shift : {1'b0, s_q.rx_shift[7:1]};
    always_comb
    begin
        status                   = '0;
        status[`URXS_ST_RXFULL]  = s_q.receive_full_flag;
        status[`URXS_ST_TXEMPTY] = transmit_empty_flag;
        status[`URXS_ST_CARRIER] = dcd_n_i;
        status[`URXS_ST_CLEAR]   = cts_n_i;
        status[`URXS_ST_FRAMING] = s_q.framing_flag;
        status[`URXS_ST_OVERRUN] = s_q.receive_overrun_flag;
        status[`URXS_ST_PARITY]  = s_q.parity_mismatch_flag;
        status[`URXS_ST_IRQ]     = s_q.irq;
    end
    always_comb
    begin
        s_d          = s_q;
        rx_src       = 1'b0;
        tx_src       = 1'b0;
        s_d.e_prev   = e_i;
        s_d.clk_prev = rxtx_clk_i;
        if (wr_ctrl)
            s_d.ctrl = data_i;
        if (sel && e_i && rw_i)
            s_d.data_out = register_select_line_i ? s_q.receive_holding_register : status;
        if (rd_data)
        begin
            if (s_q.overrun_pending)
            begin
                s_d.receive_overrun_flag = 1'b1;
                s_d.overrun_pending      = 1'b0;
            end
            else
            begin
                s_d.receive_overrun_flag = 1'b0;
                s_d.receive_full_flag    = 1'b0;
            end
        end
        if (wr_data)
            s_d.tx_irq_armed = 1'b0;
        if (rx_tick && !mreset)
        begin
            if (s_q.rx_st == rx_idle)
            begin
                s_d.rx_cnt = rxd_i ? 7'h00 : (s_q.rx_cnt + 7'h01);
                if (!rxd_i && (s_d.rx_cnt == half))
                begin
                    s_d.rx_st  = rx_data;
                    s_d.rx_cnt = '0;
                    s_d.rx_bit = '0;
                end
            end
            else
            begin
                s_d.rx_cnt = s_q.rx_cnt + 7'h01;
                if (s_d.rx_cnt == ratio)
                begin
                    s_d.rx_cnt = '0;
                    case (s_q.rx_st)
                        rx_data:
                        begin
                            s_d.rx_shift = {rxd_i, s_q.rx_shift[7:1]};
                            s_d.rx_bit   = s_q.rx_bit + 4'h1;
                            if (s_d.rx_bit == nbits)
                                s_d.rx_st = fmt.par_en ? rx_par : rx_stop;
                        end
                        rx_par:
                        begin
                            s_d.rx_parbit = rxd_i;
                            s_d.rx_st     = rx_stop;
                        end
                        rx_stop:
                        begin
                            s_d.rx_st = rx_idle;
                            if (s_d.receive_full_flag)
                                s_d.overrun_pending = 1'b1;
                            else
                            begin
                                s_d.receive_holding_register = rx_char;
                                s_d.receive_full_flag        = 1'b1;
                                s_d.framing_flag             = !rxd_i;
                                s_d.parity_mismatch_flag = fmt.par_en &&
                                    ((^rx_char ^ s_q.rx_parbit) != fmt.par_odd);
                            end
                        end
                        default:
                            s_d.rx_st = rx_idle;
                    endcase
                end
            end
        end
        // transmitter takes the next word only when idle
        if (fifo_out_valid && fifo_out_ready)
        begin
            s_d.tx_shift     = fifo_out_data;
            s_d.tx_parbit    = fmt.par_odd ^ (^(fmt.eight ? fifo_out_data : {1'b0, fifo_out_data[6:0]}));
            s_d.tx_st        = tx_start;
            s_d.tx_cnt       = '0;
            s_d.tx_bit       = '0;
            s_d.tx_irq_armed = 1'b1;
        end
        else if (tx_tick && (s_q.tx_st != tx_idle) && !mreset)
        begin
            if (s_q.tx_cnt == 7'h00)
                case (s_q.tx_st)
                    tx_start: s_d.txd = 1'b0;
                    tx_data:  s_d.txd = s_q.tx_shift[0];
                    tx_par:   s_d.txd = s_q.tx_parbit;
                    default:  s_d.txd = 1'b1;
                endcase
            s_d.tx_cnt = s_q.tx_cnt + 7'h01;
            if (s_d.tx_cnt == ratio)
            begin
                s_d.tx_cnt = '0;
                case (s_q.tx_st)
                    tx_start: s_d.tx_st = tx_data;
                    tx_data:
                    begin
                        s_d.tx_shift = {1'b0, s_q.tx_shift[7:1]};
                        s_d.tx_bit   = s_q.tx_bit + 4'h1;
                        if (s_d.tx_bit == nbits)
                            s_d.tx_st = fmt.par_en ? tx_par : tx_stop1;
                    end
                    tx_par:   s_d.tx_st = tx_stop1;
                    tx_stop1: s_d.tx_st = fmt.two_stop ? tx_stop2 : tx_idle;
                    default:  s_d.tx_st = tx_idle;
                endcase
            end
        end
        if (tc == `URXS_TC_BREAK)
            s_d.txd = 1'b0;
        else if (s_q.tx_st == tx_idle)
            s_d.txd = 1'b1;
        if (mreset)
        begin
            s_d.receive_full_flag    = 1'b0;
            s_d.receive_overrun_flag = 1'b0;
            s_d.overrun_pending      = 1'b0;
            s_d.parity_mismatch_flag = 1'b0;
            s_d.framing_flag         = 1'b0;
            s_d.rx_st                = rx_idle;
            s_d.rx_cnt               = '0;
            s_d.tx_st                = tx_idle;
            s_d.tx_cnt               = '0;
            s_d.tx_irq_armed         = 1'b1;
            s_d.txd                  = 1'b1;
        end
        rx_src = s_q.ctrl[`URXS_CR_RXIE] && (s_d.receive_full_flag || s_d.receive_overrun_flag);
        tx_src = (tc == `URXS_TC_TXIE) && transmit_empty_flag && s_d.tx_irq_armed;
        s_d.irq = !mreset && (rx_src || tx_src);
    end
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q              <= '0;
            s_q.ctrl         <= `URXS_CTRL_RESET;
            s_q.txd          <= 1'b1;
            s_q.tx_irq_armed <= 1'b1;
        end
        else
            s_q <= s_d;
    end
    // a write to a full buffer is dropped; software polls the empty flag first
    urxs_fifo #(
        .WIDTH(`URXS_DATA_W),
        .DEPTH(`URXS_FIFO_DEPTH)
    ) u_fifo (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .flush_i    (mreset),
        .in_valid_i (wr_data && !mreset),
        .in_ready_o (fifo_in_ready),
        .in_data_i  (data_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o (fifo_out_data)
    );
    assign data_o    = s_q.data_out;
    assign data_oe_o = sel && e_i && rw_i;
    assign irq_n_o   = !s_q.irq;
    assign txd_o     = s_q.txd;
    assign rts_n_o   = (tc == `URXS_TC_RTS_HIGH);
endmodule

// ==== core/urxs_defines.svh ====
// constants for the receiver status and interrupt block
`ifndef URXS_DEFINES_SVH
`define URXS_DEFINES_SVH

// status word bit positions
`define URXS_ST_RXFULL   0
`define URXS_ST_TXEMPTY  1
`define URXS_ST_CARRIER  2
`define URXS_ST_CLEAR    3
`define URXS_ST_FRAMING  4
`define URXS_ST_OVERRUN  5
`define URXS_ST_PARITY   6
`define URXS_ST_IRQ      7

// control word field positions
`define URXS_CR_DIV_LO   0
`define URXS_CR_DIV_HI   1
`define URXS_CR_WS_LO    2
`define URXS_CR_WS_HI    4
`define URXS_CR_TC_LO    5
`define URXS_CR_TC_HI    6
`define URXS_CR_RXIE     7

// control word reset value holds the block in master reset
`define URXS_CTRL_RESET  8'h03

// divide select codes
`define URXS_DIV_1       2'h0
`define URXS_DIV_16      2'h1
`define URXS_DIV_64      2'h2
`define URXS_DIV_MRESET  2'h3

// transmit control codes
`define URXS_TC_TXIE     2'h1
`define URXS_TC_RTS_HIGH 2'h2
`define URXS_TC_BREAK    2'h3

// serial clock edges per bit and per half start bit
`define URXS_RATIO_1     7'h01
`define URXS_RATIO_16    7'h10
`define URXS_RATIO_64    7'h40
`define URXS_HALF_1      7'h01
`define URXS_HALF_16     7'h08
`define URXS_HALF_64     7'h20

// character lengths
`define URXS_BITS_7      4'h7
`define URXS_BITS_8      4'h8

// transmit buffer
`define URXS_FIFO_DEPTH  32
`define URXS_DATA_W      8

`endif

// ==== core/urxs_pkg.sv ====
// types for the receiver status and interrupt block
package urxs_pkg;

    typedef enum logic [1:0] {rx_idle, rx_data, rx_par, rx_stop} urxs_rx_t;

    typedef enum logic [2:0] {tx_idle, tx_start, tx_data, tx_par, tx_stop1, tx_stop2} urxs_tx_t;

    typedef struct packed {
        logic eight;
        logic par_en;
        logic par_odd;
        logic two_stop;
    } urxs_fmt_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] receive_holding_register;
        logic       receive_full_flag;
        logic       receive_overrun_flag;
        logic       overrun_pending;
        logic       parity_mismatch_flag;
        logic       framing_flag;
        logic       e_prev;
        logic       clk_prev;
        urxs_rx_t   rx_st;
        logic [6:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_shift;
        logic       rx_parbit;
        urxs_tx_t   tx_st;
        logic [6:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [7:0] tx_shift;
        logic       tx_parbit;
        logic       txd;
        logic       tx_irq_armed;
        logic       irq;
        logic [7:0] data_out;
    } urxs_state_t;

endpackage

// ==== core/urxs_fifo.sv ====
// transmit holding fifo with registered read data
module urxs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             flush_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0]      wptr;
        logic [AW:0]      rptr;
        logic             ov;
        logic [WIDTH-1:0] od;
    } urxs_fifo_state_t;

    urxs_fifo_state_t s_q;
    urxs_fifo_state_t s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             mem_empty;
    logic             push;
    logic             load;

    assign mem_empty   = (s_q.wptr == s_q.rptr);
    assign in_ready_o  = !((s_q.wptr[AW] != s_q.rptr[AW]) && (s_q.wptr[AW-1:0] == s_q.rptr[AW-1:0]));
    assign push        = in_valid_i && in_ready_o;
    assign load        = !mem_empty && (!s_q.ov || out_ready_i);
    assign out_valid_o = s_q.ov;
    assign out_data_o  = s_q.od;

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.wptr = s_q.wptr + 1'b1;
        end
        if (out_ready_i && s_q.ov)
        begin
            s_d.ov = 1'b0;
        end
        if (load)
        begin
            s_d.od   = mem_q[s_q.rptr[AW-1:0]];
            s_d.ov   = 1'b1;
            s_d.rptr = s_q.rptr + 1'b1;
        end
        if (flush_i)
        begin
            s_d = '0;
        end
    end

    // storage has no reset; the pointers alone decide what is valid
    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem_q[s_q.wptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule

// ==== bench/urxs_ser_model.sv ====
// serial peripheral model: drives the shared serial clock and the receive line
module urxs_ser_model (
    // pacing clock
    input  wire logic clock_i,
    // serial side
    output logic      rxtx_clk_o,
    output logic      rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // clock stands still low outside frames, line idles at mark
    initial
    begin
        rxtx_clk_o = 1'b0;
        rxd_o = 1'b1;
    end

    // data changes while the clock is low, sampled at its rising edge
    task automatic tick(input logic b);
        @(negedge clock_i);
        rxtx_clk_o = 1'b0;
        rxd_o = b;
        repeat (4) @(negedge clock_i);
        rxtx_clk_o = 1'b1;
        repeat (3) @(negedge clock_i);
    endtask

    task automatic send(input logic [7:0] d, input logic pe, input logic odd, input logic bad);
        tick(1'b0);
        for (int i = 0; i < 8; i++)
            tick(d[i]);
        if (pe)
            tick(^d ^ odd ^ bad);
        tick(1'b1);
        @(negedge clock_i);
        rxtx_clk_o = 1'b0;
        repeat (8) @(negedge clock_i);
    endtask

    // free clocking with a quiet line lets the transmitter drain
    task automatic run(input int n);
        repeat (n) tick(1'b1);
        @(negedge clock_i);
        rxtx_clk_o = 1'b0;
    endtask
endmodule

// ==== bench/urxs_top_asserts.sv ====
// port-level checks for the receiver status and interrupt block
module urxs_top_asserts (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // processor bus
    input  wire logic       e_i,
    input  wire logic       cs0_i,
    input  wire logic       cs1_i,
    input  wire logic       cs2_n_i,
    input  wire logic       register_select_line_i,
    input  wire logic       rw_i,
    input  wire logic [7:0] data_i,
    input  wire logic [7:0] data_o,
    input  wire logic       data_oe_o,
    input  wire logic       irq_n_o
);
    logic       e_prev_q;
    logic [7:0] ctrl_q;
    logic       sel;
    logic       st_rd;
    logic       fall;

    assign sel = cs0_i & cs1_i & ~cs2_n_i;
    assign st_rd = sel & e_i & rw_i & ~register_select_line_i;
    assign fall = e_prev_q & ~e_i & sel;

    // control is write-only, so a mirror is kept here
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            e_prev_q <= 1'b0;
            ctrl_q   <= 8'h03;
        end
        else
        begin
            e_prev_q <= e_i;
            if (fall && !register_select_line_i && !rw_i)
                ctrl_q <= data_i;
        end
    end

    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    property p_oe;
        data_oe_o == (sel && e_i && rw_i);
    endproperty
    a_oe: assert property (p_oe) else $error("bus drive enable wrong");
    property p_irq_bit;
        st_rd |=> data_o[7] == !$past(irq_n_o);
    endproperty
    a_irq_bit: assert property (p_irq_bit) else $error("status top bit wrong");
    property p_ovr_full;
        st_rd |=> (data_o[0] || !data_o[5]);
    endproperty
    a_ovr_full: assert property (p_ovr_full) else $error("overrun without full");
    property p_no_par;
        st_rd && ctrl_q[4:3] == 2'h2 |=> !data_o[6];
    endproperty
    a_no_par: assert property (p_no_par) else $error("parity flag in no-parity format");
    property p_mr_quiet;
        ctrl_q[1:0] == 2'h3 |=> irq_n_o;
    endproperty
    a_mr_quiet: assert property (p_mr_quiet) else $error("request during master reset");
    property p_irq_en;
        !irq_n_o |-> $past(ctrl_q[7] || ctrl_q[6:5] == 2'h1);
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("request with no enable");
    property p_rx_irq;
        st_rd && ctrl_q[7] && ctrl_q[1:0] != 2'h3 ##1 data_o[0] |-> !irq_n_o;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("full without request");
    property p_tx_rel;
        fall && register_select_line_i && !rw_i && !ctrl_q[7] |-> ##2 irq_n_o;
    endproperty
    a_tx_rel: assert property (p_tx_rel) else $error("request kept after write");
endmodule

bind urxs_top urxs_top_asserts urxs_top_asserts_inst (
    .clock_i, .rst_i, .e_i, .cs0_i, .cs1_i, .cs2_n_i, .register_select_line_i,
    .rw_i, .data_i, .data_o, .data_oe_o, .irq_n_o
);

// ==== bench/tb_urxs_top.sv ====
// self-checking bench for the receiver status and interrupt block
module tb_urxs_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       e_i = 1'b0;
    logic       register_select_line_i = 1'b0;
    logic       rw_i = 1'b1;
    logic [7:0] data_i = 8'h00;
    logic       cts_n_i = 1'b0;
    logic       dcd_n_i = 1'b0;
    logic [7:0] data_o;
    logic       data_oe_o;
    logic       irq_n_o;
    logic       txd_o;
    logic       rts_n_o;
    logic       sclk;
    logic       rxd;
    logic [7:0] rd;
    logic [7:0] ptab [5] = '{8'h98, 8'h98, 8'h9C, 8'h9C, 8'h90};
    int         miscompares = 0;
    int         tests_run = 0;

    always #20 clock_i = ~clock_i;

    urxs_top urxs_top_inst (
        .clock_i, .rst_i, .e_i, .cs0_i(1'b1), .cs1_i(1'b1), .cs2_n_i(1'b0),
        .register_select_line_i, .rw_i, .data_i, .data_o, .data_oe_o, .irq_n_o,
        .rxtx_clk_i(sclk), .rxd_i(rxd), .txd_o, .cts_n_i, .dcd_n_i, .rts_n_o
    );
    urxs_ser_model urxs_ser_model_inst (.clock_i, .rxtx_clk_o(sclk), .rxd_o(rxd));

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        tests_run++;
        if ((got & m) !== (exp & m))
        begin
            miscompares++;
            $display("ERROR at %0t: read %h, wanted %h under mask %h", $time, got, exp, m);
        end
    endtask

    // one access: enable high one cycle, acts when it falls
    task automatic acc(input logic rs, input logic rw, input logic [7:0] d);
        @(negedge clock_i);
        register_select_line_i = rs;
        rw_i = rw;
        data_i = d;
        e_i = 1'b1;
        @(negedge clock_i);
        e_i = 1'b0;
        rd = data_o;
    endtask

    task automatic st(input logic [7:0] exp, input logic [7:0] m);
        acc(1'b0, 1'b1, 8'h00);
        chk(rd, exp, m);
    endtask

    task automatic rdat(input logic [7:0] exp);
        acc(1'b1, 1'b1, 8'h00);
        chk(rd, exp, 8'hFF);
    endtask

    // master reset first so every scenario starts from clear flags
    task automatic setup(input logic [7:0] v);
        acc(1'b0, 1'b0, 8'h03);
        acc(1'b0, 1'b0, v);
    endtask

    // request line moves one clock after the access edge
    task automatic irq_is(input logic exp_n);
        repeat (2) @(negedge clock_i);
        chk({7'h00, irq_n_o}, {7'h00, exp_n}, 8'h01);
    endtask

    // one frame at divide-by-one; the first tick has no falling edge since the clock stands low
    task automatic tx_frame(input logic [7:0] ctl, input logic [7:0] d);
        logic [10:0] exp;
        exp = {1'b1, ctl[3] ? ^d : 1'b1, d, 1'b0};
        setup(ctl);
        acc(1'b1, 1'b0, d);
        urxs_ser_model_inst.tick(1'b1);
        for (int i = 0; i < 11; i++)
        begin
            urxs_ser_model_inst.tick(1'b1);
            chk({7'h00, txd_o}, {7'h00, exp[i]}, 8'h01);
        end
        urxs_ser_model_inst.run(0);
    endtask

    initial
    begin
        repeat (16) @(negedge clock_i);
        rst_i = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            setup({1'b0, c[1:0], 5'h14});
            irq_is(c != 1);
            st({c == 1, 7'h02}, 8'h82);
            chk({7'h00, rts_n_o}, {7'h00, c == 2}, 8'h01);
            acc(1'b1, 1'b0, 8'h55);
            irq_is(1'b1);
        end
        setup(8'h14);
        for (int i = 0; i < 34; i++)
            acc(1'b1, 1'b0, i[7:0]);
        st(8'h00, 8'h02);
        urxs_ser_model_inst.run(400);
        st(8'h02, 8'h02);
        chk({7'h00, txd_o}, 8'h01, 8'h01);
        tx_frame(8'h10, 8'hC3);
        tx_frame(8'h18, 8'h5B);
        cts_n_i = 1'b1;
        dcd_n_i = 1'b1;
        setup(8'h14);
        st(8'h0C, 8'h0E);
        cts_n_i = 1'b0;
        dcd_n_i = 1'b0;
        st(8'h02, 8'h0E);
        for (int k = 0; k < 5; k++)
        begin
            setup(ptab[k]);
            urxs_ser_model_inst.send(8'hA5 + k[7:0], k < 4, k[1], k[0]);
            st({1'b1, k[0], 5'h00, 1'b1}, 8'hC1);
            st({1'b1, k[0], 5'h00, 1'b1}, 8'hC1);
            rdat(8'hA5 + k[7:0]);
            irq_is(1'b1);
            st(8'h00, 8'h81);
        end
        setup(8'h14);
        urxs_ser_model_inst.send(8'h11, 1'b0, 1'b0, 1'b0);
        urxs_ser_model_inst.send(8'h22, 1'b0, 1'b0, 1'b0);
        urxs_ser_model_inst.send(8'h33, 1'b0, 1'b0, 1'b0);
        irq_is(1'b1);
        st(8'h01, 8'h21);
        rdat(8'h11);
        st(8'h21, 8'h21);
        rdat(8'h11);
        st(8'h00, 8'h21);
        urxs_ser_model_inst.send(8'h5A, 1'b0, 1'b0, 1'b0);
        rdat(8'h5A);
        urxs_ser_model_inst.send(8'h66, 1'b0, 1'b0, 1'b0);
        urxs_ser_model_inst.send(8'h77, 1'b0, 1'b0, 1'b0);
        rdat(8'h66);
        setup(8'h14);
        st(8'h00, 8'h21);
        close_out();
    end

    // hang guard
    initial
    begin
        repeat (60000) @(posedge clock_i);
        miscompares++;
        close_out();
    end
endmodule
